// file: hw/data_ram.sv
// Internal data memory, 256 bytes, registered read data
module data_ram (
  input wire logic mclk,
  mem_if.store     bus
);
  logic [7:0] mem [0:255];

  // Write on strobe, read data always registered
  always_ff @(posedge mclk)
  begin
    if (bus.we)
    begin
      mem[bus.addr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.addr];
  end
endmodule : data_ram

// file: hw/exec_unit.sv
// Execution unit for multiply, idle and byte-OR instructions
module exec_unit (
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire logic           instr_valid,
  output logic                instr_ready,
  input  wire exec_pkg::byte_t opcode,
  input  wire exec_pkg::byte_t operand1,
  input  wire exec_pkg::byte_t operand2,
  input  wire exec_pkg::byte_t port_pins,
  output exec_pkg::byte_t      port_latch,
  output exec_pkg::byte_t      acc,
  output exec_pkg::byte_t      aux,
  output exec_pkg::byte_t      psw,
  output exec_pkg::word_t      pc,
  output logic                done,
  output logic                illegal
);
  import exec_pkg::*;

  state_t     state_r;
  state_t     state_nxt;
  logic [3:0] cnt_r;
  byte_t      opcode_r;
  byte_t      operand1_r;
  byte_t      operand2_r;
  byte_t      acc_r;
  byte_t      aux_r;
  byte_t      psw_r;
  byte_t      latch_r;
  word_t      pc_r;
  byte_t      first_r;
  word_t      res_r;
  byte_t      rd_addr_r;
  logic       rd_dir_r;
  logic       done_r;
  logic       illegal_r;

  mem_if mbus ();

  data_ram u_ram (
    .mclk (mclk),
    .bus  (mbus.store)
  );

  // Instruction decode
  wire is_mul    = (opcode_r == OP_MUL);
  wire is_nop    = (opcode_r == OP_NOP);
  wire is_or_reg = (opcode_r[7:3] == OP_OR_REG);
  wire is_or_ind = (opcode_r[7:1] == OP_OR_IND);
  wire is_or_dir = (opcode_r == OP_OR_DIR);
  wire is_or_imm = (opcode_r == OP_OR_IMM);
  wire is_or_da  = (opcode_r == OP_OR_DIR_A);
  wire is_or_di  = (opcode_r == OP_OR_DIR_I);
  wire is_or_a   = is_or_reg | is_or_ind | is_or_dir | is_or_imm;
  wire is_or_d   = is_or_da | is_or_di;
  wire is_bad    = !(is_mul | is_nop | is_or_a | is_or_d);

  // Instruction length and duration
  wire [1:0] len_bytes = is_or_di ? 2'd3 :
                         (is_or_dir | is_or_imm | is_or_da) ? 2'd2 : 2'd1;
  wire [3:0] last_cnt  = is_mul ? LAST_MUL :
                         is_or_di ? LAST_TWO : LAST_ONE;

  // Handshake and commit strobe
  wire accept = instr_valid && instr_ready;
  wire commit = (state_r == st_wait) && (cnt_r == last_cnt);
  assign instr_ready = (state_r == st_idle);

  // Register bank address of Rn or @Ri pointer
  wire [2:0] reg_idx   = is_or_reg ? opcode_r[2:0] : {2'b00, opcode_r[0]};
  wire [7:0] bank_addr = {3'b000, psw_r[PSW_RS1:PSW_RS0], reg_idx};
  wire       first_dir = !(is_or_reg | is_or_ind);
  wire [7:0] first_addr = first_dir ? operand1_r : bank_addr;

  // Status word as seen by reads: parity follows accumulator
  wire [7:0] psw_view = {psw_r[7:1], ^acc_r};

  // Direct reads of the unit's own registers; port read by OR targets
  // the output latch, any other direct read sees the pins
  wire [7:0] port_src = is_or_d ? latch_r : port_pins;
  wire [7:0] read_val = !rd_dir_r                ? mbus.rdata :
                        (rd_addr_r == ACC_ADDR)  ? acc_r :
                        (rd_addr_r == AUX_ADDR)  ? aux_r :
                        (rd_addr_r == PSW_ADDR)  ? psw_view :
                        (rd_addr_r == PORT_ADDR) ? port_src : mbus.rdata;

  // Operand selection for OR
  wire [7:0] src_val = is_or_ind ? mbus.rdata : first_r;
  wire [7:0] or_lhs  = is_or_d ? first_r : acc_r;
  wire [7:0] or_rhs  = is_or_imm ? operand1_r :
                       is_or_da  ? acc_r :
                       is_or_di  ? operand2_r : src_val;
  wire [7:0]  or_res  = or_lhs | or_rhs;
  wire [15:0] product = 16'(acc_r) * 16'(aux_r);

  // Destination decode of direct-address OR
  wire dst_acc  = is_or_d && (operand1_r == ACC_ADDR);
  wire dst_aux  = is_or_d && (operand1_r == AUX_ADDR);
  wire dst_psw  = is_or_d && (operand1_r == PSW_ADDR);
  wire dst_port = is_or_d && (operand1_r == PORT_ADDR);
  wire dst_ram  = is_or_d && !(dst_acc | dst_aux | dst_psw | dst_port);

  // Memory port: read pointer/direct, then indirect, write at commit
  assign mbus.addr  = (state_r == st_ptr)  ? first_addr :
                      (state_r == st_opnd) ? mbus.rdata : operand1_r;
  assign mbus.we    = commit && dst_ram;
  assign mbus.wdata = res_r[7:0];

  // Architectural next values, all updated on the same commit edge
  wire [7:0] acc_nxt = !commit ? acc_r :
                       is_mul ? res_r[7:0] :
                       (is_or_a | dst_acc) ? res_r[7:0] : acc_r;
  wire [7:0] aux_nxt = !commit ? aux_r :
                       is_mul ? res_r[15:8] :
                       dst_aux ? res_r[7:0] : aux_r;
  wire       ov_nxt  = |res_r[15:8];
  wire [7:0] mul_psw = {1'b0, psw_r[6:3], ov_nxt, psw_r[1:0]};
  wire [7:0] psw_nxt = !commit ? psw_r :
                       is_mul ? mul_psw :
                       dst_psw ? res_r[7:0] : psw_r;
  wire [7:0] latch_nxt = (commit && dst_port) ? res_r[7:0] : latch_r;
  wire [15:0] pc_nxt = commit ? pc_r + 16'(len_bytes) : pc_r;

  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_idle: if (accept) state_nxt = st_ptr;
      st_ptr:  state_nxt = st_opnd;
      st_opnd: state_nxt = st_exec;
      st_exec: state_nxt = st_wait;
      st_wait: if (commit) state_nxt = st_idle;
      default: state_nxt = st_idle;
    endcase
  end

  // State and machine-cycle counter
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= st_idle;
      cnt_r   <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt == st_idle) ? 4'h0 :
                 (state_r == st_idle) ? 4'h0 : cnt_r + 4'h1;
    end
  end

  // Instruction capture
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      opcode_r   <= OP_NOP;
      operand1_r <= 8'h00;
      operand2_r <= 8'h00;
    end
    else if (accept)
    begin
      opcode_r   <= opcode;
      operand1_r <= operand1;
      operand2_r <= operand2;
    end
  end

  // Operand fetch tracking and result staging
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rd_addr_r <= 8'h00;
      rd_dir_r  <= 1'b0;
      first_r   <= 8'h00;
      res_r     <= 16'h0000;
    end
    else
    begin
      rd_addr_r <= mbus.addr;
      rd_dir_r  <= (state_r == st_ptr) && first_dir;
      if (state_r == st_opnd)
        first_r <= read_val;
      if (state_r == st_exec)
        res_r <= is_mul ? product : {8'h00, or_res};
    end
  end

  // Architectural registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      acc_r   <= ACC_RST;
      aux_r   <= AUX_RST;
      psw_r   <= PSW_RST;
      latch_r <= PORT_RST;
      pc_r    <= PC_RST;
    end
    else
    begin
      acc_r   <= acc_nxt;
      aux_r   <= aux_nxt;
      psw_r   <= psw_nxt;
      latch_r <= latch_nxt;
      pc_r    <= pc_nxt;
    end
  end

  // Completion pulses
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
    end
    else
    begin
      done_r    <= commit;
      illegal_r <= commit && is_bad;
    end
  end

  assign acc        = acc_r;
  assign aux        = aux_r;
  assign psw        = psw_view;
  assign pc         = pc_r;
  assign port_latch = latch_r;
  assign done       = done_r;
  assign illegal    = illegal_r;

  // Snapshot of state at acceptance, read only by the checks below
  byte_t snap_acc;
  byte_t snap_aux;
  byte_t snap_psw;
  byte_t snap_latch;
  word_t snap_pc;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      snap_acc   <= 8'h00;
      snap_aux   <= 8'h00;
      snap_psw   <= 8'h00;
      snap_latch <= 8'h00;
      snap_pc    <= 16'h0000;
    end
    else if (accept)
    begin
      snap_acc   <= acc_r;
      snap_aux   <= aux_r;
      snap_psw   <= psw_r;
      snap_latch <= latch_r;
      snap_pc    <= pc_r;
    end
  end

  // Cycles since the last acceptance, saturating, for the timing checks
  logic [4:0] since_acc_r;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      since_acc_r <= 5'h00;
    end
    else if (accept)
    begin
      since_acc_r <= 5'h01;
    end
    else if (since_acc_r != 5'h1f)
    begin
      since_acc_r <= since_acc_r + 5'h01;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  mul_time_a: assert property (
    accept && opcode == OP_MUL |-> ##17 done_r)
    else $error("multiply did not finish after four machine cycles");

  mul_early_a: assert property (
    done_r && is_mul |-> since_acc_r == 5'h11)
    else $error("multiply finished before four machine cycles");

  mul_product_a: assert property (
    done_r && is_mul |-> {aux_r, acc_r} == 16'(snap_acc) * 16'(snap_aux))
    else $error("multiply product bytes wrong");

  mul_ov_a: assert property (
    done_r && is_mul |-> psw_r[PSW_OV] == (aux_r != 8'h00))
    else $error("multiply overflow flag wrong");

  mul_cy_a: assert property (
    done_r && is_mul |-> !psw_r[PSW_CY] && psw_r[6:3] == snap_psw[6:3])
    else $error("multiply did not clear carry");

  nop_only_pc_a: assert property (
    accept && opcode == OP_NOP |-> ##5 done_r && pc_r == snap_pc + 16'h1
      && acc_r == snap_acc && aux_r == snap_aux && psw_r == snap_psw)
    else $error("idle instruction changed more than the counter");

  or_acc_imm_a: assert property (
    done_r && is_or_imm |-> acc_r == (snap_acc | operand1_r))
    else $error("OR immediate into accumulator wrong");

  or_flags_a: assert property (
    done_r && (is_or_a || (is_or_d && !dst_psw)) |-> psw_r == snap_psw)
    else $error("byte OR changed a status flag");

  or_dir_time_a: assert property (
    accept && opcode == OP_OR_DIR_I |-> ##9 done_r && pc_r == snap_pc + 16'h3)
    else $error("OR direct with immediate timing or length wrong");

  or_port_a: assert property (
    done_r && dst_port && is_or_di |-> latch_r == (snap_latch | operand2_r))
    else $error("port OR did not start from the latch");

  or_ram_write_a: assert property (
    commit && dst_ram |-> mbus.we && mbus.addr == operand1_r
      && mbus.wdata == (first_r | (is_or_di ? operand2_r : snap_acc)))
    else $error("direct OR did not write its destination");

  busy_stable_a: assert property (
    state_r != st_idle && !commit |=> $stable(acc_r) && $stable(aux_r)
      && $stable(psw_r))
    else $error("result visible before completion");

endmodule : exec_unit

// file: pkg/exec_pkg.sv
// Constants and types for the multiply, idle and byte-OR execution unit
// Functional notes
// - Multiply takes unsigned bytes, opcode a4, four machine cycles
// - Product low byte to accumulator, high to auxiliary
// - Overflow set when product above 255, else cleared
// - Multiply always clears carry
// - Idle instruction only advances program counter by one
// - OR writes bitwise OR of operands to destination
// - Byte OR leaves status flags unchanged, except parity and a status word destination
// - Six OR operand combinations are supported
// - Port modify reads output latch, not pins
// - Direct OR sets mask bits in any location
package exec_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;

  typedef enum logic [2:0] {
    st_idle,
    st_ptr,
    st_opnd,
    st_exec,
    st_wait
  } state_t;

  // Opcodes of the supported instructions
  localparam byte_t OP_MUL      = 8'ha4;
  localparam byte_t OP_NOP      = 8'h00;
  localparam byte_t OP_OR_DIR_A = 8'h42;
  localparam byte_t OP_OR_DIR_I = 8'h43;
  localparam byte_t OP_OR_IMM   = 8'h44;
  localparam byte_t OP_OR_DIR   = 8'h45;
  localparam logic [6:0] OP_OR_IND = 7'h23;   // 0100011i
  localparam logic [4:0] OP_OR_REG = 5'h09;   // 01001rrr

  // Special function register addresses held inside the unit
  localparam byte_t ACC_ADDR  = 8'he0;
  localparam byte_t AUX_ADDR  = 8'hf0;
  localparam byte_t PSW_ADDR  = 8'hd0;
  localparam byte_t PORT_ADDR = 8'h90;

  // Status word fields
  localparam int PSW_CY  = 7;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV  = 2;

  // Reset values
  localparam byte_t ACC_RST  = 8'h00;
  localparam byte_t AUX_RST  = 8'h00;
  localparam byte_t PSW_RST  = 8'h00;
  localparam byte_t PORT_RST = 8'hff;
  localparam word_t PC_RST   = 16'h0000;

  // Machine cycle timing
  localparam int CLK_NS  = 10;
  localparam int MC_NS   = 40;
  localparam int MC_CLKS = (MC_NS + CLK_NS - 1) / CLK_NS;
  localparam int MUL_MC  = 4;
  localparam int ONE_MC  = 1;
  localparam int TWO_MC  = 2;
  localparam logic [3:0] LAST_MUL = 4'(MUL_MC * MC_CLKS - 1);
  localparam logic [3:0] LAST_ONE = 4'(ONE_MC * MC_CLKS - 1);
  localparam logic [3:0] LAST_TWO = 4'(TWO_MC * MC_CLKS - 1);

endpackage : exec_pkg

// file: pkg/mem_if.sv
// Port between the execution unit and its internal data memory
interface mem_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic [7:0] rdata;

  modport ctrl  (output addr, output wdata, output we, input rdata);
  modport store (input addr, input wdata, input we, output rdata);
endinterface : mem_if

// file: sim/tb_top.sv
// Self-checking bench for the multiply, idle and byte-OR execution unit
`define chk(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import exec_pkg::*;

  logic  mclk;
  logic  reset;
  logic  instr_valid;
  logic  instr_ready;
  byte_t opcode;
  byte_t operand1;
  byte_t operand2;
  byte_t port_pins;
  byte_t port_latch;
  byte_t acc;
  byte_t aux;
  byte_t psw;
  word_t pc;
  logic  done;
  logic  illegal;
  int    mismatches;
  int    checks_done;
  int    cyc;
  word_t epc;

  exec_unit exec_unit_inst (
    .mclk        (mclk),
    .reset       (reset),
    .instr_valid (instr_valid),
    .instr_ready (instr_ready),
    .opcode      (opcode),
    .operand1    (operand1),
    .operand2    (operand2),
    .port_pins   (port_pins),
    .port_latch  (port_latch),
    .acc         (acc),
    .aux         (aux),
    .psw         (psw),
    .pc          (pc),
    .done        (done),
    .illegal     (illegal)
  );

  // Free-running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic results;
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Cuts a hung run short
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      results();
    end
  end

  // Values that reset must show
  task automatic t_reset_vals;
    `chk(acc, 8'h00)
    `chk(aux, 8'h00)
    `chk(psw, 8'h00)
    `chk(pc, 16'h0000)
    `chk(port_latch, 8'hff)
    `chk(instr_ready, 1'b1)
    `chk(done, 1'b0)
  endtask : t_reset_vals

  // One instruction: accept, wait for done, check length and timing
  task automatic exec(input byte_t op, input byte_t a1, input byte_t a2,
                      input int len, input int n, input logic ill);
    int k;
    opcode = op;
    operand1 = a1;
    operand2 = a2;
    instr_valid = 1'b1;
    @(posedge mclk);
    #1;
    instr_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 40)
    begin
      `chk(instr_ready, 1'b0)
      @(posedge mclk);
      #1;
      k++;
    end
    epc = epc + 16'(len);
    `chk(k, n)
    `chk(pc, epc)
    `chk(illegal, ill)
    `chk(psw[0], ^acc)
  endtask : exec

  // Multiply with result and flags checked in the done cycle
  task automatic mulchk(input byte_t ea, input byte_t eb, input logic ov);
    exec(OP_MUL, 8'h00, 8'h00, 1, 16, 1'b0);
    `chk({acc, aux}, {ea, eb})
    `chk(psw[PSW_OV], ov)
    `chk(psw[PSW_CY], 1'b0)
  endtask : mulchk

  // OR instruction whose flags must stay put
  task automatic orx(input byte_t op, input byte_t a1, input byte_t a2,
                     input int len, input int n);
    byte_t p;
    p = psw;
    // A status word destination takes the mask as a plain data write
    if (op == OP_OR_DIR_I && a1 == PSW_ADDR)
      p = p | a2;
    exec(op, a1, a2, len, n, 1'b0);
    `chk(psw[7:1], p[7:1])
  endtask : orx

  // Multiply cases including the 255 boundary
  task automatic t_mul;
    orx(OP_OR_DIR_I, PSW_ADDR, 8'h80, 3, 8);
    orx(OP_OR_IMM, 8'h50, 8'h00, 2, 4);
    orx(OP_OR_DIR_I, AUX_ADDR, 8'ha0, 3, 8);
    mulchk(8'h00, 8'h32, 1'b1);
    orx(OP_OR_IMM, 8'h08, 8'h00, 2, 4);
    mulchk(8'h90, 8'h01, 1'b1);
    orx(OP_OR_DIR_I, PSW_ADDR, 8'h80, 3, 8);
    orx(OP_OR_IMM, 8'hff, 8'h00, 2, 4);
    mulchk(8'hff, 8'h00, 1'b0);
  endtask : t_mul

  // Idle and unsupported opcodes change only the program counter
  task automatic t_nop;
    byte_t a;
    byte_t b;
    byte_t p;
    a = acc;
    b = aux;
    p = psw;
    exec(OP_NOP, 8'h00, 8'h00, 1, 4, 1'b0);
    `chk({acc, aux, psw}, {a, b, p})
    exec(8'ha5, 8'h00, 8'h00, 1, 4, 1'b1);
    `chk({acc, aux, psw}, {a, b, p})
  endtask : t_nop

  // All six OR combinations
  task automatic t_or;
    orx(OP_OR_DIR_I, PSW_ADDR, 8'h24, 3, 8);
    orx(OP_OR_DIR_I, 8'h00, 8'hff, 3, 8);
    orx(OP_OR_DIR_I, 8'h01, 8'hff, 3, 8);
    orx(OP_OR_DIR_I, 8'hff, 8'hff, 3, 8);
    mulchk(8'h00, 8'h00, 1'b0);
    orx({OP_OR_REG, 3'd0}, 8'h00, 8'h00, 1, 4);
    `chk(acc, 8'hff)
    mulchk(8'h00, 8'h00, 1'b0);
    orx({OP_OR_IND, 1'b1}, 8'h00, 8'h00, 1, 4);
    `chk(acc, 8'hff)
    mulchk(8'h00, 8'h00, 1'b0);
    port_pins = 8'h5a;
    orx(OP_OR_DIR, PORT_ADDR, 8'h00, 2, 4);
    `chk(acc, 8'h5a)
    orx(OP_OR_IMM, 8'h81, 8'h00, 2, 4);
    `chk(acc, 8'hdb)
    port_pins = 8'h00;
    orx(OP_OR_DIR_I, PORT_ADDR, 8'h00, 3, 8);
    `chk(port_latch, 8'hff)
    orx(OP_OR_DIR_A, AUX_ADDR, 8'h00, 2, 4);
    `chk(aux, 8'hdb)
    orx(OP_OR_DIR_I, AUX_ADDR, 8'h24, 3, 8);
    `chk(aux, 8'hff)
  endtask : t_or

  // Main sequence
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    cyc = 0;
    epc = PC_RST;
    reset = 1'b1;
    instr_valid = 1'b0;
    opcode = 8'h00;
    operand1 = 8'h00;
    operand2 = 8'h00;
    port_pins = 8'h00;
    repeat (10) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_reset_vals();
    t_mul();
    t_nop();
    t_or();
    reset = 1'b1;
    #1;
    t_reset_vals();
    @(posedge mclk);
    #1;
    reset = 1'b0;
    t_reset_vals();
    epc = PC_RST;
    exec(OP_NOP, 8'h00, 8'h00, 1, 4, 1'b0);
    results();
  end
endmodule : tb_top
